/* rtl/bmf_port_ctrl.sv */
// Port control of a unidirectional bus-matching FIFO: mailboxes, resets, rewind, port decode
// Behaviour
// - Port B read: mailbox if selected, else FIFO
// - Port B mailbox write goes only to mailbox
// - A-to-B flag drops on its mailbox write
// - A-to-B mailbox write ignored while flag low
// - A-to-B flag rises on Port B mailbox read
// - Full and flush resets leave A-to-B flag high
// - B-to-A flag drops on its mailbox write
// - B-to-A mailbox write blocked while flag low
// - B-to-A flag rises on Port A mailbox read
// - Resets leave B-to-A flag high
// - Reset low clears pointers and output register
// - Full reset latches offset, size, endian setup
// - Mailbox reset low clears B-to-A mailbox
// - Flush reset keeps the latched configuration
// - Rewind strobe returns read pointer to zero
// - Rewind acts only in standard timing mode
// - Size high gives 9 bits, low 18
// - Serial load select picks offset loading method
// - Port A direction high writes, low reads
// - Port B direction low writes, high reads
// - Port A moves only with gate high
// - Port B moves only with select low
// - Port A mailbox select steers to mailbox
`timescale 1ns/1ps
module bmf_port_ctrl
  import bmf_pkg::*;
#(
  parameter int FIFO_DEPTH = BMF_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Port pins, all asynchronous to i_clk
  input wire bmf_a_pins_s i_a_pins,
  input wire bmf_b_pins_s i_b_pins,
  input wire bmf_misc_pins_s i_misc_pins,
  input wire bmf_cfg_s i_cfg_pins,
  // Port A read data
  output logic [35:0] o_a_data,
  output logic o_a_data_oe,
  // Port B read data
  output logic [35:0] o_b_data,
  output logic o_b_data_oe,
  // Status
  output logic o_a_to_b_mail_flag_n,
  output logic o_b_to_a_mail_flag_n,
  output logic o_fifo_ready,
  output logic o_fifo_empty_n,
  output bmf_cfg_s o_active_cfg,
  output logic [7:0] o_default_offset
);

  // Three-stage pin synchronisers
  bmf_a_pins_s a_s1_q, a_s2_q, a_s3_q;
  bmf_b_pins_s b_s1_q, b_s2_q, b_s3_q;
  bmf_misc_pins_s m_s1_q, m_s2_q, m_s3_q;
  bmf_cfg_s c_s1_q, c_s2_q, c_s3_q;

  // Stage 1 feeds only stage 2; the level filters read stages 2 and 3, the rest of the decode stage 3
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      a_s1_q <= BMF_A_RESET;
      a_s2_q <= BMF_A_RESET;
      a_s3_q <= BMF_A_RESET;
    end
    else
    begin
      a_s1_q <= i_a_pins;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      b_s1_q <= BMF_B_RESET;
      b_s2_q <= BMF_B_RESET;
      b_s3_q <= BMF_B_RESET;
    end
    else
    begin
      b_s1_q <= i_b_pins;
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      m_s1_q <= BMF_MISC_RESET;
      m_s2_q <= BMF_MISC_RESET;
      m_s3_q <= BMF_MISC_RESET;
    end
    else
    begin
      m_s1_q <= i_misc_pins;
      m_s2_q <= m_s1_q;
      m_s3_q <= m_s2_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      c_s1_q <= BMF_CFG_RESET;
      c_s2_q <= BMF_CFG_RESET;
      c_s3_q <= BMF_CFG_RESET;
    end
    else
    begin
      c_s1_q <= i_cfg_pins;
      c_s2_q <= c_s1_q;
      c_s3_q <= c_s2_q;
    end
  end

  // Filtered levels of the port clocks and the reset and mode pins
  logic a_clk_q, b_clk_q;
  bmf_misc_pins_s m_lvl_q, m_prev_q;

  wire logic [35:0] a_clk_f = bmf_filter({35'h0, a_s2_q.a_side_clock},
                                         {35'h0, a_s3_q.a_side_clock}, {35'h0, a_clk_q});
  wire logic [35:0] b_clk_f = bmf_filter({35'h0, b_s2_q.b_side_clock},
                                         {35'h0, b_s3_q.b_side_clock}, {35'h0, b_clk_q});
  wire logic [35:0] m_f = bmf_filter({31'h0, m_s2_q}, {31'h0, m_s3_q}, {31'h0, m_lvl_q});
  wire bmf_misc_pins_s m_lvl_d = m_f[4:0];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
      m_lvl_q <= BMF_MISC_RESET;
      m_prev_q <= BMF_MISC_RESET;
    end
    else
    begin
      a_clk_q <= a_clk_f[0];
      b_clk_q <= b_clk_f[0];
      m_lvl_q <= m_lvl_d;
      m_prev_q <= m_lvl_q;
    end
  end

  // Port decode at each detected port-clock rising edge
  wire logic a_rise = a_clk_f[0] && !a_clk_q;
  wire logic b_rise = b_clk_f[0] && !b_clk_q;
  wire logic a_xfer = a_rise && a_s3_q.a_side_gate;
  wire logic a_wr = a_xfer && a_s3_q.a_side_direction;
  wire logic a_rd = a_xfer && !a_s3_q.a_side_direction;
  wire logic a_mb_wr = a_wr && a_s3_q.a_side_mailbox_select;
  wire logic a_mb_rd = a_rd && a_s3_q.a_side_mailbox_select;
  wire logic a_fifo_wr = a_wr && !a_s3_q.a_side_mailbox_select;
  wire logic b_xfer = b_rise && !b_s3_q.b_side_select_n;
  wire logic b_wr = b_xfer && !b_s3_q.b_side_direction;
  wire logic b_rd = b_xfer && b_s3_q.b_side_direction;
  wire logic b_mb_wr = b_wr && b_s3_q.b_side_mailbox_select;
  wire logic b_mb_rd = b_rd && b_s3_q.b_side_mailbox_select;
  wire logic b_fifo_rd = b_rd && !b_s3_q.b_side_mailbox_select;

  // Reset decode
  wire logic clr_all = i_sys_rst || !m_lvl_q.full_reset_n || !m_lvl_q.flush_reset_n;
  wire logic full_release = m_lvl_q.full_reset_n && !m_prev_q.full_reset_n;
  wire logic rewind_strobe = !m_lvl_q.rewind_n && m_prev_q.rewind_n;
  wire logic rewind_go = rewind_strobe && !m_lvl_q.fall_through_mode;

  // Active configuration, latched only when the full reset is released
  bmf_cfg_s cfg_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cfg_q <= BMF_CFG_RESET;
    end
    else if (full_release)
    begin
      cfg_q <= c_s3_q;
    end
  end

  wire logic [35:0] width_mask = bmf_width_mask(cfg_q);
  wire logic [1:0] last_lane = bmf_last_lane(cfg_q);
  wire logic [7:0] sel_offset = (cfg_q.offset_sel == BMF_SEL_OFFSET_8) ? BMF_OFFSET_8 :
                                (cfg_q.offset_sel == BMF_SEL_OFFSET_16) ? BMF_OFFSET_16 :
                                (cfg_q.offset_sel == BMF_SEL_OFFSET_64) ? BMF_OFFSET_64 :
                                BMF_OFFSET_NONE;

  // Mailboxes and their flags
  logic [35:0] a_to_b_mailbox_q, b_to_a_mailbox_q;
  logic a_to_b_mail_flag_n_q, b_to_a_mail_flag_n_q;

  wire logic a_to_b_store = a_mb_wr && a_to_b_mail_flag_n_q;
  wire logic b_to_a_store = b_mb_wr && b_to_a_mail_flag_n_q;
  wire logic b_to_a_clr = clr_all || !m_lvl_q.mailbox_reset_n;

  // A store and a read in one cycle leave the mail pending

  always_ff @(posedge i_clk)
  begin
    if (clr_all)
    begin
      a_to_b_mail_flag_n_q <= 1'b1;
      a_to_b_mailbox_q <= BMF_WORD_ZERO;
    end
    else if (a_to_b_store)
    begin
      a_to_b_mail_flag_n_q <= 1'b0;
      a_to_b_mailbox_q <= a_s3_q.data & width_mask;
    end
    else if (b_mb_rd)
    begin
      a_to_b_mail_flag_n_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (b_to_a_clr)
    begin
      b_to_a_mail_flag_n_q <= 1'b1;
      b_to_a_mailbox_q <= BMF_WORD_ZERO;
    end
    else if (b_to_a_store)
    begin
      b_to_a_mail_flag_n_q <= 1'b0;
      b_to_a_mailbox_q <= b_s3_q.data & width_mask;
    end
    else if (a_mb_rd)
    begin
      b_to_a_mail_flag_n_q <= 1'b1;
    end
  end

  // FIFO in the A-to-B data path
  logic fifo_wr_ready, fifo_rd_valid;
  logic [35:0] fifo_rd_data;
  logic [1:0] lane_q;
  logic load_pend_q;

  wire logic fifo_push = a_fifo_wr && fifo_wr_ready;
  wire logic lane_start = (lane_q == BMF_LANE_FIRST);
  wire logic fifo_pop = b_fifo_rd && lane_start && fifo_rd_valid;
  wire logic lane_more = b_fifo_rd && !lane_start;
  wire logic [1:0] lane_after_pop = (last_lane == BMF_LANE_FIRST) ? BMF_LANE_FIRST : 2'h1;
  wire logic [1:0] lane_next = (lane_q == last_lane) ? BMF_LANE_FIRST : lane_q + 2'h1;

  bmf_fifo #(
    .WIDTH(BMF_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(clr_all),
    .i_rewind(rewind_go),
    .i_wr_valid(a_fifo_wr),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data(a_s3_q.data),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_pop),
    .o_rd_data(fifo_rd_data)
  );

  // Port B output register and lane sequencing
  logic [35:0] b_word_q, b_out_q, a_out_q;

  // A pop cut short by a rewind must not load a stale word
  always_ff @(posedge i_clk)
  begin
    if (clr_all)
    begin
      lane_q <= BMF_LANE_FIRST;
      load_pend_q <= 1'b0;
    end
    else
    begin
      load_pend_q <= fifo_pop && !rewind_go;
      if (rewind_go)
      begin
        lane_q <= BMF_LANE_FIRST;
      end
      else if (fifo_pop)
      begin
        lane_q <= lane_after_pop;
      end
      else if (lane_more)
      begin
        lane_q <= lane_next;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (clr_all)
    begin
      b_out_q <= BMF_WORD_ZERO;
      b_word_q <= BMF_WORD_ZERO;
    end
    else if (load_pend_q)
    begin
      b_word_q <= fifo_rd_data;
      b_out_q <= bmf_lane_pick(fifo_rd_data, BMF_LANE_FIRST, cfg_q);
    end
    else if (lane_more)
    begin
      b_out_q <= bmf_lane_pick(b_word_q, lane_q, cfg_q);
    end
    else if (b_mb_rd)
    begin
      b_out_q <= a_to_b_mailbox_q & width_mask;
    end
  end

  // Port A read data from the B-to-A mailbox
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      a_out_q <= BMF_WORD_ZERO;
    end
    else if (a_mb_rd)
    begin
      a_out_q <= b_to_a_mailbox_q;
    end
  end

  assign o_a_data = a_out_q;
  assign o_a_data_oe = !a_s3_q.a_side_direction;
  assign o_b_data = b_out_q;
  assign o_b_data_oe = b_s3_q.b_side_direction && !b_s3_q.b_side_select_n;
  assign o_a_to_b_mail_flag_n = a_to_b_mail_flag_n_q;
  assign o_b_to_a_mail_flag_n = b_to_a_mail_flag_n_q;
  assign o_fifo_ready = fifo_wr_ready;
  assign o_fifo_empty_n = fifo_rd_valid;
  assign o_active_cfg = cfg_q;
  assign o_default_offset = cfg_q.serial_offset_load_n ? sel_offset : BMF_OFFSET_NONE;

endmodule // bmf_port_ctrl

/* rtl/bmf_pkg.sv */
// Shared constants, pin carriers and decode functions of the bus-matching FIFO port control
package bmf_pkg;

  localparam int BMF_WORD_W = 36;
  localparam int BMF_FIFO_DEPTH = 16;
  localparam logic [35:0] BMF_WORD_ZERO = 36'h000000000;
  localparam logic [35:0] BMF_MASK_36 = 36'hFFFFFFFFF;
  localparam logic [35:0] BMF_MASK_18 = 36'h00003FFFF;
  localparam logic [35:0] BMF_MASK_9 = 36'h0000001FF;
  localparam logic [1:0] BMF_LAST_LANE_36 = 2'h0;
  localparam logic [1:0] BMF_LAST_LANE_18 = 2'h1;
  localparam logic [1:0] BMF_LAST_LANE_9 = 2'h3;
  localparam logic [1:0] BMF_LANE_FIRST = 2'h0;
  localparam logic [7:0] BMF_OFFSET_8 = 8'h08;
  localparam logic [7:0] BMF_OFFSET_16 = 8'h10;
  localparam logic [7:0] BMF_OFFSET_64 = 8'h40;
  localparam logic [7:0] BMF_OFFSET_NONE = 8'h00;
  localparam logic [1:0] BMF_SEL_OFFSET_8 = 2'h0;
  localparam logic [1:0] BMF_SEL_OFFSET_16 = 2'h1;
  localparam logic [1:0] BMF_SEL_OFFSET_64 = 2'h2;

  typedef struct packed {
    logic a_side_clock;
    logic a_side_gate;
    logic a_side_direction;
    logic a_side_mailbox_select;
    logic [35:0] data;
  } bmf_a_pins_s;

  typedef struct packed {
    logic b_side_clock;
    logic b_side_select_n;
    logic b_side_direction;
    logic b_side_mailbox_select;
    logic [35:0] data;
  } bmf_b_pins_s;

  typedef struct packed {
    logic full_reset_n;
    logic flush_reset_n;
    logic mailbox_reset_n;
    logic rewind_n;
    logic fall_through_mode;
  } bmf_misc_pins_s;

  typedef struct packed {
    logic serial_offset_load_n;
    logic [1:0] offset_sel;
    logic bus_match_select;
    logic bus_size_byte;
    logic endian_select;
  } bmf_cfg_s;

  localparam bmf_a_pins_s BMF_A_RESET = '{1'b0, 1'b0, 1'b1, 1'b0, 36'h000000000};
  localparam bmf_b_pins_s BMF_B_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 36'h000000000};
  localparam bmf_misc_pins_s BMF_MISC_RESET = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam bmf_cfg_s BMF_CFG_RESET = '{1'b1, 2'h0, 1'b0, 1'b0, 1'b0};

  // Level filter: follows the input once the last two stages agree
  function automatic logic [BMF_WORD_W-1:0] bmf_filter(input logic [BMF_WORD_W-1:0] s2,
                                                       input logic [BMF_WORD_W-1:0] s3,
                                                       input logic [BMF_WORD_W-1:0] lvl);
    return (s2 & s3) | (lvl & (s2 | s3));
  endfunction

  function automatic logic [1:0] bmf_last_lane(input bmf_cfg_s c);
    logic [1:0] r;
    r = BMF_LAST_LANE_36;
    if (c.bus_match_select)
    begin
      r = c.bus_size_byte ? BMF_LAST_LANE_9 : BMF_LAST_LANE_18;
    end
    return r;
  endfunction

  function automatic logic [35:0] bmf_width_mask(input bmf_cfg_s c);
    logic [35:0] r;
    r = BMF_MASK_36;
    if (c.bus_match_select)
    begin
      r = c.bus_size_byte ? BMF_MASK_9 : BMF_MASK_18;
    end
    return r;
  endfunction

  // Picks the Port B lane of a long-word; big endian sends the top lane first
  function automatic logic [35:0] bmf_lane_pick(input logic [35:0] w, input logic [1:0] lane,
                                                input bmf_cfg_s c);
    logic [1:0] idx;
    logic [35:0] r;
    idx = c.endian_select ? (bmf_last_lane(c) - lane) : lane;
    r = w;
    if (c.bus_match_select && c.bus_size_byte)
    begin
      unique case (idx)
        2'h0: r = {27'h0000000, w[8:0]};
        2'h1: r = {27'h0000000, w[17:9]};
        2'h2: r = {27'h0000000, w[26:18]};
        2'h3: r = {27'h0000000, w[35:27]};
      endcase
    end
    else if (c.bus_match_select)
    begin
      r = idx[0] ? {18'h00000, w[35:18]} : {18'h00000, w[17:0]};
    end
    return r;
  endfunction

endpackage

/* rtl/bmf_fifo.sv */
// Data FIFO with registered read data, clear and rewind of the read pointer
`timescale 1ns/1ps
module bmf_fifo
  import bmf_pkg::*;
#(
  parameter int WIDTH = BMF_WORD_W,
  parameter int DEPTH = BMF_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_rewind,
  // Fill side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Drain side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] written_q;
  logic [WIDTH-1:0] rd_data_q;

  wire logic push = i_wr_valid && o_wr_ready;
  wire logic pop = i_rd_ready && o_rd_valid && !i_rewind;
  wire logic [CNT_W-1:0] written_next = (push && written_q != DEPTH_C) ? written_q + CNT_ONE
                                                                       : written_q;

  assign o_wr_ready = (count_q != DEPTH_C);
  assign o_rd_valid = (count_q != '0);
  assign o_rd_data = rd_data_q;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clear)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      written_q <= '0;
      rd_data_q <= '0;
    end
    else
    begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      written_q <= written_next;
      if (i_rewind)
      begin
        // Replay starts again from location zero
        rd_ptr_q <= '0;
        count_q <= written_next;
      end
      else
      begin
        rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_q <= count_q + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);
      end
      if (pop)
      begin
        rd_data_q <= mem[rd_ptr_q];
      end
    end
  end

endmodule // bmf_fifo

/* bench/bmf_port_ctrl_asserts.sv */
// Concurrent checks on the port-control pins and status outputs
`timescale 1ns/1ps
module bmf_port_ctrl_asserts
  import bmf_pkg::*;
#(
  parameter int FIFO_DEPTH = BMF_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pins
  input wire bmf_a_pins_s i_a_pins,
  input wire bmf_b_pins_s i_b_pins,
  input wire bmf_misc_pins_s i_misc_pins,
  input wire bmf_cfg_s i_cfg_pins,
  // Outputs watched
  input wire logic [35:0] o_a_data,
  input wire logic o_a_data_oe,
  input wire logic [35:0] o_b_data,
  input wire logic o_b_data_oe,
  input wire logic o_a_to_b_mail_flag_n,
  input wire logic o_b_to_a_mail_flag_n,
  input wire logic o_fifo_ready,
  input wire logic o_fifo_empty_n,
  input wire bmf_cfg_s o_active_cfg,
  input wire logic [7:0] o_default_offset
);
  // Cycles since any reset pin was last low, saturating
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  wire logic rst_pins_n = i_misc_pins.full_reset_n & i_misc_pins.flush_reset_n
    & i_misc_pins.mailbox_reset_n;
  assign quiet_d = !rst_pins_n ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
  always_ff @(posedge i_clk) quiet_q <= i_sys_rst ? 4'h0 : quiet_d;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_ab_fall_write: assert property ($fell(o_a_to_b_mail_flag_n) |-> i_a_pins.a_side_clock
    && i_a_pins.a_side_gate && i_a_pins.a_side_direction && i_a_pins.a_side_mailbox_select)
    else $error("A-to-B flag fell without a Port A mailbox write");
  a_ba_fall_write: assert property ($fell(o_b_to_a_mail_flag_n) |-> i_b_pins.b_side_clock
    && !i_b_pins.b_side_select_n && !i_b_pins.b_side_direction && i_b_pins.b_side_mailbox_select)
    else $error("B-to-A flag fell without a Port B mailbox write");
  a_ab_rise_read: assert property ($rose(o_a_to_b_mail_flag_n) && quiet_q == 4'hF
    |-> i_b_pins.b_side_clock && !i_b_pins.b_side_select_n && i_b_pins.b_side_direction
    && i_b_pins.b_side_mailbox_select) else $error("A-to-B flag rose without a mailbox read");
  a_ba_rise_read: assert property ($rose(o_b_to_a_mail_flag_n) && quiet_q == 4'hF
    |-> i_a_pins.a_side_clock && i_a_pins.a_side_gate && !i_a_pins.a_side_direction
    && i_a_pins.a_side_mailbox_select) else $error("B-to-A flag rose without a mailbox read");
  a_b_oe_select: assert property (i_b_pins.b_side_select_n [*5] |-> !o_b_data_oe)
    else $error("Port B drives while deselected");
  a_b_oe_dir: assert property (!i_b_pins.b_side_direction [*5] |-> !o_b_data_oe)
    else $error("Port B drives while writing");
  a_a_oe_dir: assert property (i_a_pins.a_side_direction [*5] |-> !o_a_data_oe)
    else $error("Port A drives while writing");
  a_a_oe_read: assert property (!i_a_pins.a_side_direction [*5] |-> o_a_data_oe)
    else $error("Port A does not drive while reading");
  a_b_oe_read: assert property ((!i_b_pins.b_side_select_n && i_b_pins.b_side_direction)
    [*5] |-> o_b_data_oe) else $error("Port B does not drive while reading");
  a_reset_clears: assert property ((!i_misc_pins.full_reset_n || !i_misc_pins.flush_reset_n)
    [*6] |-> o_b_data == BMF_WORD_ZERO && o_a_to_b_mail_flag_n
    && o_b_to_a_mail_flag_n) else $error("Reset did not clear output and flags");
  a_cfg_kept: assert property (i_misc_pins.full_reset_n [*6] |=> $stable(o_active_cfg))
    else $error("Active configuration changed without a full reset");
endmodule // bmf_port_ctrl_asserts

bind bmf_port_ctrl bmf_port_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_a_pins(i_a_pins), .i_b_pins(i_b_pins),
  .i_misc_pins(i_misc_pins), .i_cfg_pins(i_cfg_pins), .o_a_data(o_a_data),
  .o_a_data_oe(o_a_data_oe), .o_b_data(o_b_data), .o_b_data_oe(o_b_data_oe),
  .o_a_to_b_mail_flag_n(o_a_to_b_mail_flag_n), .o_b_to_a_mail_flag_n(o_b_to_a_mail_flag_n),
  .o_fifo_ready(o_fifo_ready), .o_fifo_empty_n(o_fifo_empty_n),
  .o_active_cfg(o_active_cfg), .o_default_offset(o_default_offset));

/* bench/bmf_host_agent.sv */
// Processor model on Ports A and B: one port clock cycle per access
`timescale 1ns/1ps
module bmf_host_agent
  import bmf_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Port pins
  output bmf_a_pins_s o_a_pins,
  output bmf_b_pins_s o_b_pins
);
  initial
  begin
    o_a_pins = BMF_A_RESET;
    o_b_pins = BMF_B_RESET;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Fields settle, port clock high and low six cycles each, then data is released
  task automatic a_xfer(input logic gate, input logic wr, input logic mb, input logic [35:0] d);
    tick(1);
    o_a_pins.a_side_gate = gate;
    o_a_pins.a_side_direction = wr;
    o_a_pins.a_side_mailbox_select = mb;
    o_a_pins.data = d;
    tick(2);
    o_a_pins.a_side_clock = 1'b1;
    tick(6);
    o_a_pins.a_side_clock = 1'b0;
    tick(6);
    o_a_pins.a_side_gate = 1'b0;
    o_a_pins.a_side_direction = 1'b1;
    o_a_pins.data = ~d;
  endtask
  task automatic b_xfer(input logic sel_n, input logic rd, input logic mb, input logic [35:0] d);
    tick(1);
    o_b_pins.b_side_select_n = sel_n;
    o_b_pins.b_side_direction = rd;
    o_b_pins.b_side_mailbox_select = mb;
    o_b_pins.data = d;
    tick(2);
    o_b_pins.b_side_clock = 1'b1;
    tick(6);
    o_b_pins.b_side_clock = 1'b0;
    tick(6);
    o_b_pins.b_side_select_n = 1'b1;
    o_b_pins.b_side_direction = 1'b0;
    o_b_pins.data = ~d;
  endtask
endmodule // bmf_host_agent

/* bench/tb_bus_matching_fifo_port_control.sv */
// Self-checking testbench of the bus-matching FIFO port control
`timescale 1ns/1ps
module tb_bus_matching_fifo_port_control;
  import bmf_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  bmf_a_pins_s a_pins;
  bmf_b_pins_s b_pins;
  bmf_misc_pins_s misc = BMF_MISC_RESET;
  bmf_cfg_s cfg = BMF_CFG_RESET;
  bmf_cfg_s act_cfg;
  bmf_cfg_s kept;
  logic [35:0] a_data;
  logic [35:0] b_data;
  logic a_oe;
  logic b_oe;
  logic ab_n;
  logic ba_n;
  logic f_ready;
  logic f_empty_n;
  logic [7:0] dflt_off;
  logic [35:0] word = 36'h9ABCDEF12;
  int error_cnt = 0;
  int checked = 0;
  int w;
  int idx;
  always #5 i_clk = ~i_clk;
  bmf_host_agent host_u (.i_clk(i_clk), .o_a_pins(a_pins), .o_b_pins(b_pins));
  bmf_port_ctrl #(.FIFO_DEPTH(BMF_FIFO_DEPTH)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_a_pins(a_pins), .i_b_pins(b_pins),
    .i_misc_pins(misc), .i_cfg_pins(cfg), .o_a_data(a_data), .o_a_data_oe(a_oe),
    .o_b_data(b_data), .o_b_data_oe(b_oe), .o_a_to_b_mail_flag_n(ab_n),
    .o_b_to_a_mail_flag_n(ba_n), .o_fifo_ready(f_ready), .o_fifo_empty_n(f_empty_n),
    .o_active_cfg(act_cfg), .o_default_offset(dflt_off));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Full or flush reset held over four clock edges of each port
  task automatic reset_pins(input logic full, input bmf_cfg_s c);
    cfg = c;
    misc.full_reset_n = !full;
    misc.flush_reset_n = full;
    repeat (4)
    begin
      host_u.a_xfer(1'b0, 1'b1, 1'b0, 36'h0);
      host_u.b_xfer(1'b1, 1'b0, 1'b0, 36'h0);
    end
    misc.full_reset_n = 1'b1;
    misc.flush_reset_n = 1'b1;
    step(8);
  endtask
  task automatic pulse_rewind();
    misc.rewind_n = 1'b0;
    step(6);
    misc.rewind_n = 1'b1;
    step(6);
  endtask
  initial
  begin
    step(12);
    i_sys_rst = 1'b0;
    step(6);
    for (int s = 0; s < 5; s++)
    begin
      reset_pins(1'b1, '{s < 4, s[1:0], 1'b1, 1'b0, 1'b0});
      check(dflt_off, (s == 0) ? BMF_OFFSET_8 : (s == 1) ? BMF_OFFSET_16 :
        (s == 2) ? BMF_OFFSET_64 : BMF_OFFSET_NONE);
      check(act_cfg, cfg);
    end
    check(b_data, BMF_WORD_ZERO);
    check(ab_n, 1'b1);
    check(ba_n, 1'b1);
    check(a_oe, 1'b0);
    check(b_oe, 1'b0);
    host_u.a_xfer(1'b1, 1'b1, 1'b1, 36'hABCDE1234);
    check(ab_n, 1'b0);
    host_u.a_xfer(1'b1, 1'b1, 1'b1, 36'h111111111);
    host_u.b_xfer(1'b1, 1'b1, 1'b1, 36'h0);
    check(ab_n, 1'b0);
    host_u.b_xfer(1'b0, 1'b1, 1'b1, 36'h0);
    check(b_data, 36'hABCDE1234 & BMF_MASK_18);
    check(ab_n, 1'b1);
    host_u.b_xfer(1'b0, 1'b0, 1'b1, 36'h00002BEEF);
    check(ba_n, 1'b0);
    host_u.b_xfer(1'b0, 1'b0, 1'b1, 36'h000015555);
    host_u.a_xfer(1'b0, 1'b0, 1'b1, 36'h0);
    check(ba_n, 1'b0);
    host_u.a_xfer(1'b1, 1'b0, 1'b1, 36'h0);
    check(a_data, 36'h00002BEEF);
    check(ba_n, 1'b1);
    host_u.b_xfer(1'b0, 1'b0, 1'b0, 36'h000000003);
    check(f_empty_n, 1'b0);
    host_u.b_xfer(1'b0, 1'b0, 1'b1, 36'h000000001);
    misc.mailbox_reset_n = 1'b0;
    step(8);
    misc.mailbox_reset_n = 1'b1;
    step(6);
    check(ba_n, 1'b1);
    host_u.a_xfer(1'b1, 1'b0, 1'b1, 36'h0);
    check(a_data, BMF_WORD_ZERO);
    // Lane order: 9-bit big endian, 18-bit little endian, then full long-word
    for (int k = 2; k >= 0; k--)
    begin
      reset_pins(1'b1, '{1'b1, 2'h0, k > 0, k == 2, k == 2});
      host_u.a_xfer(1'b1, 1'b1, 1'b0, word);
      check(f_empty_n, 1'b1);
      w = (k == 2) ? 9 : (k == 1) ? 18 : 36;
      for (int j = 0; j < 36 / w; j++)
      begin
        host_u.b_xfer(1'b0, 1'b1, 1'b0, 36'h0);
        idx = (k == 2) ? (36 / w - 1 - j) : j;
        check(b_data, (word >> (idx * w)) & ((36'h1 << w) - 36'h1));
      end
      check(f_empty_n, 1'b0);
    end
    host_u.b_xfer(1'b0, 1'b1, 1'b1, 36'h0);
    check(b_data, BMF_WORD_ZERO);
    misc.fall_through_mode = 1'b1;
    pulse_rewind();
    check(f_empty_n, 1'b0);
    misc.fall_through_mode = 1'b0;
    pulse_rewind();
    check(f_empty_n, 1'b1);
    host_u.b_xfer(1'b0, 1'b1, 1'b0, 36'h0);
    check(b_data, word);
    for (int i = 0; i < BMF_FIFO_DEPTH + 1; i++)
      host_u.a_xfer(1'b1, 1'b1, 1'b0, 36'(i));
    check(f_ready, 1'b0);
    for (int i = 0; i < BMF_FIFO_DEPTH; i++)
    begin
      host_u.b_xfer(1'b0, 1'b1, 1'b0, 36'h0);
      check(b_data, 36'(i));
    end
    check(f_empty_n, 1'b0);
    check(f_ready, 1'b1);
    host_u.a_xfer(1'b1, 1'b1, 1'b0, word);
    host_u.a_xfer(1'b1, 1'b1, 1'b1, word);
    kept = act_cfg;
    reset_pins(1'b0, '{1'b0, 2'h2, 1'b1, 1'b0, 1'b1});
    check(act_cfg, kept);
    check(f_empty_n, 1'b0);
    check(ab_n, 1'b1);
    give_verdict();
  end
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_bus_matching_fifo_port_control
